// ### hdl/bus_seq_pkg.sv
// Constants and types shared by the bus cycle sequencer.
// Assumes one bus cycle per mclk period.
package bus_seq_pkg;

    // Instruction groups the sequencer knows how to run
    typedef enum logic [3:0] {
        k_idx_store_accumulator,
        k_idx_read_modify_write,
        k_idx_store_word,
        k_idx_call_subroutine,
        k_ext_jump_absolute,
        k_ext_read_operand,
        k_ext_load_word,
        k_ext_store_accumulator,
        k_ext_read_modify_write
    } op_kind_t;

    // Clock
    localparam int unsigned MCLK_PERIOD_NS = 50;

    // Cycle numbering
    localparam logic [3:0] CYC_IDLE   = 4'h0;
    localparam logic [3:0] CYC_OPCODE = 4'h1;
    localparam logic [3:0] CYC_SECOND = 4'h2;
    localparam logic [3:0] CYC_THIRD  = 4'h3;
    localparam logic [3:0] CYC_FOURTH = 4'h4;
    localparam logic [3:0] CYC_FIFTH  = 4'h5;
    localparam logic [3:0] CYC_SIXTH  = 4'h6;
    localparam logic [3:0] CYC_SEVENTH = 4'h7;
    localparam logic [3:0] CYC_EIGHTH = 4'h8;

    // Cycle counts per instruction group
    localparam logic [3:0] LEN_IDX_STORE_ACC = 4'h6;
    localparam logic [3:0] LEN_IDX_RMW       = 4'h7;
    localparam logic [3:0] LEN_IDX_STORE_WORD = 4'h7;
    localparam logic [3:0] LEN_IDX_CALL      = 4'h8;
    localparam logic [3:0] LEN_EXT_JUMP      = 4'h3;
    localparam logic [3:0] LEN_EXT_READ      = 4'h4;
    localparam logic [3:0] LEN_EXT_LOAD_WORD = 4'h5;
    localparam logic [3:0] LEN_EXT_STORE_ACC = 4'h5;
    localparam logic [3:0] LEN_EXT_RMW       = 4'h6;

    // Address steps
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;

    // Values after reset; ADDR_RST and BYTE_RST also while idle, WORD_RST also on start
    localparam logic [15:0] ADDR_RST  = 16'h0000;
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [15:0] WORD_RST  = 16'h0000;

endpackage : bus_seq_pkg

// ### hdl/hold_reg.sv
// Register with load enable.
// Assumes a single clock and asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module hold_reg #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Load
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    // Held value
    output logic      [W-1:0] held_q
);

    logic [W-1:0] held_d;

    always_comb
    begin
        held_d = load ? value : held_q;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            held_q <= '0;
        else
            held_q <= held_d;
    end

endmodule : hold_reg
`default_nettype wire

// ### hdl/offset_adder.sv
// Adds an unsigned 8-bit offset to a 16-bit base.
// With CARRY at 0 the high byte of the base passes unchanged.
`timescale 1ns/1ps
`default_nettype none
module offset_adder #(
    parameter bit CARRY = 1'b1
) (
    // Operands
    input  wire logic [15:0] base,
    input  wire logic [7:0]  offset,
    // Result
    output logic      [15:0] sum
);

    always_comb
    begin
        if (CARRY)
            sum = 16'(base + {8'h00, offset});
        else
            sum = {base[15:8], 8'(base[7:0] + offset)};
    end

endmodule : offset_adder
`default_nettype wire

// ### hdl/bus_cycle_sequencer.sv
// Bus cycle sequencer for indexed and extended instructions.
// Assumes the core supplies the instruction group at start and keeps
// accumulator, word and new operand data valid when written.
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_sequencer (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // Instruction start
    input  wire logic                   start,
    input  wire bus_seq_pkg::op_kind_t  kind,
    input  wire logic                   test_only,
    input  wire logic [15:0]            opcode_addr,
    input  wire logic [15:0]            index_reg,
    input  wire logic [15:0]            stack_ptr,
    // Data to be written
    input  wire logic [7:0]             acc_data,
    input  wire logic [15:0]            word_data,
    input  wire logic [7:0]             new_data,
    // Bus
    input  wire logic [7:0]             data_in,
    output logic      [15:0]            addr_q,
    output logic                        valid_memory_address_q,
    output logic                        rd_wr_n_q,
    output logic      [7:0]             data_out_q,
    // Status and results
    output logic                        busy,
    output logic                        last_cycle_q,
    output logic      [3:0]             cycle_q,
    output logic      [15:0]            operand_q,
    output logic      [15:0]            target_q
);

    bus_seq_pkg::op_kind_t kind_q;
    bus_seq_pkg::op_kind_t kind_d;
    logic [3:0]  cycle_d;
    logic        test_q;
    logic        test_d;
    logic [7:0]  addr_hi_q;
    logic [7:0]  addr_hi_d;
    logic [7:0]  addr_lo_q;
    logic [7:0]  addr_lo_d;
    logic [15:0] operand_d;
    logic [15:0] addr_d;
    logic        vma_d;
    logic        rd_wr_n_d;
    logic [7:0]  data_out_d;
    logic        last_cycle_d;
    logic        take;
    logic        at_end;
    logic [3:0]  length_now;
    logic [3:0]  length_next;
    logic [15:0] pc_held_q;
    logic [15:0] ix_held_q;
    logic [15:0] sp_held_q;
    logic [15:0] pc_v;
    logic [15:0] ix_v;
    logic [15:0] sp_v;
    logic [15:0] ix_nc;
    logic [15:0] ix_ea;
    logic [15:0] ext_ea;
    logic [15:0] ret_addr;

    // Cycle count of each group
    function automatic logic [3:0] length_of(input bus_seq_pkg::op_kind_t k);
        logic [3:0] n;
        n = bus_seq_pkg::LEN_EXT_JUMP;
        unique case (k)
            bus_seq_pkg::k_idx_store_accumulator: n = bus_seq_pkg::LEN_IDX_STORE_ACC;
            bus_seq_pkg::k_idx_read_modify_write: n = bus_seq_pkg::LEN_IDX_RMW;
            bus_seq_pkg::k_idx_store_word:        n = bus_seq_pkg::LEN_IDX_STORE_WORD;
            bus_seq_pkg::k_idx_call_subroutine:   n = bus_seq_pkg::LEN_IDX_CALL;
            bus_seq_pkg::k_ext_jump_absolute:     n = bus_seq_pkg::LEN_EXT_JUMP;
            bus_seq_pkg::k_ext_read_operand:      n = bus_seq_pkg::LEN_EXT_READ;
            bus_seq_pkg::k_ext_load_word:         n = bus_seq_pkg::LEN_EXT_LOAD_WORD;
            bus_seq_pkg::k_ext_store_accumulator: n = bus_seq_pkg::LEN_EXT_STORE_ACC;
            bus_seq_pkg::k_ext_read_modify_write: n = bus_seq_pkg::LEN_EXT_RMW;
            default:                              n = bus_seq_pkg::LEN_EXT_JUMP;
        endcase
        return n;
    endfunction : length_of

    function automatic logic is_indexed(input bus_seq_pkg::op_kind_t k);
        return (k == bus_seq_pkg::k_idx_store_accumulator) || (k == bus_seq_pkg::k_idx_read_modify_write) ||
               (k == bus_seq_pkg::k_idx_store_word) || (k == bus_seq_pkg::k_idx_call_subroutine);
    endfunction : is_indexed

    // Start is accepted while idle or in the last cycle
    assign length_now = length_of(kind_q);
    assign at_end     = (cycle_q == bus_seq_pkg::CYC_IDLE) || (cycle_q == length_now);
    assign take       = at_end && start;
    assign busy       = (cycle_q != bus_seq_pkg::CYC_IDLE);

    // Base addresses held for the whole instruction
    hold_reg #(
        .W      (16)
    ) u_pc_hold (
        .mclk   (mclk),
        .rst    (rst),
        .load   (take),
        .value  (opcode_addr),
        .held_q (pc_held_q)
    );

    hold_reg #(
        .W      (16)
    ) u_ix_hold (
        .mclk   (mclk),
        .rst    (rst),
        .load   (take),
        .value  (index_reg),
        .held_q (ix_held_q)
    );

    hold_reg #(
        .W      (16)
    ) u_sp_hold (
        .mclk   (mclk),
        .rst    (rst),
        .load   (take),
        .value  (stack_ptr),
        .held_q (sp_held_q)
    );

    assign pc_v = take ? opcode_addr : pc_held_q;
    assign ix_v = take ? index_reg : ix_held_q;
    assign sp_v = take ? stack_ptr : sp_held_q;

    // Index plus offset, without and with carry into the high byte
    offset_adder #(
        .CARRY  (1'b0)
    ) u_ix_nocarry (
        .base   (ix_v),
        .offset (addr_lo_d),
        .sum    (ix_nc)
    );

    offset_adder #(
        .CARRY  (1'b1)
    ) u_ix_full (
        .base   (ix_v),
        .offset (addr_lo_d),
        .sum    (ix_ea)
    );

    assign ext_ea   = {addr_hi_d, addr_lo_d};
    assign ret_addr = 16'(pc_v + bus_seq_pkg::STEP_TWO);

    // Sequencing and capture of read data
    always_comb
    begin
        cycle_d   = cycle_q;
        kind_d    = kind_q;
        test_d    = test_q;
        addr_hi_d = addr_hi_q;
        addr_lo_d = addr_lo_q;
        // Read capture below wins over the clear on take
        operand_d = take ? bus_seq_pkg::WORD_RST : operand_q;
        if (busy && valid_memory_address_q && rd_wr_n_q)
        begin
            if (cycle_q == bus_seq_pkg::CYC_SECOND)
            begin
                if (is_indexed(kind_q))
                    addr_lo_d = data_in;
                else
                    addr_hi_d = data_in;
            end
            else if (cycle_q == bus_seq_pkg::CYC_THIRD && !is_indexed(kind_q))
                addr_lo_d = data_in;
            else if (cycle_q >= bus_seq_pkg::CYC_FOURTH)
                operand_d = {operand_q[7:0], data_in};
        end
        if (take)
        begin
            cycle_d   = bus_seq_pkg::CYC_OPCODE;
            kind_d    = kind;
            test_d    = test_only;
        end
        else if (at_end)
            cycle_d = bus_seq_pkg::CYC_IDLE;
        else
            cycle_d = 4'(cycle_q + 4'h1);
    end

    // Bus content of the cycle about to begin
    always_comb
    begin
        length_next  = length_of(kind_d);
        addr_d       = bus_seq_pkg::ADDR_RST;
        vma_d        = 1'b0;
        rd_wr_n_d    = 1'b1;
        data_out_d   = bus_seq_pkg::BYTE_RST;
        last_cycle_d = (cycle_d != bus_seq_pkg::CYC_IDLE) && (cycle_d == length_next);
        if (cycle_d == bus_seq_pkg::CYC_OPCODE)
        begin
            addr_d = pc_v;
            vma_d  = 1'b1;
        end
        else if (cycle_d == bus_seq_pkg::CYC_SECOND)
        begin
            addr_d = 16'(pc_v + bus_seq_pkg::STEP_ONE);
            vma_d  = 1'b1;
        end
        else if (cycle_d != bus_seq_pkg::CYC_IDLE)
        begin
            unique case (kind_d)
                bus_seq_pkg::k_idx_store_accumulator:
                begin
                    unique case (cycle_d)
                        bus_seq_pkg::CYC_THIRD:  addr_d = ix_v;
                        bus_seq_pkg::CYC_FOURTH: addr_d = ix_nc;
                        bus_seq_pkg::CYC_FIFTH:  addr_d = ix_ea;
                        default:
                        begin
                            addr_d     = ix_ea;
                            vma_d      = 1'b1;
                            rd_wr_n_d  = 1'b0;
                            data_out_d = acc_data;
                        end
                    endcase
                end
                bus_seq_pkg::k_idx_read_modify_write:
                begin
                    unique case (cycle_d)
                        bus_seq_pkg::CYC_THIRD:  addr_d = ix_v;
                        bus_seq_pkg::CYC_FOURTH: addr_d = ix_nc;
                        bus_seq_pkg::CYC_FIFTH:
                        begin
                            addr_d = ix_ea;
                            vma_d  = 1'b1;
                        end
                        bus_seq_pkg::CYC_SIXTH:  addr_d = ix_ea;
                        default:
                        begin
                            addr_d = ix_ea;
                            vma_d  = !test_d;
                            if (!test_d)
                            begin
                                rd_wr_n_d  = 1'b0;
                                data_out_d = new_data;
                            end
                        end
                    endcase
                end
                bus_seq_pkg::k_idx_store_word:
                begin
                    unique case (cycle_d)
                        bus_seq_pkg::CYC_THIRD:  addr_d = ix_v;
                        bus_seq_pkg::CYC_FOURTH: addr_d = ix_nc;
                        bus_seq_pkg::CYC_FIFTH:  addr_d = ix_ea;
                        bus_seq_pkg::CYC_SIXTH:
                        begin
                            addr_d     = ix_ea;
                            vma_d      = 1'b1;
                            rd_wr_n_d  = 1'b0;
                            data_out_d = word_data[15:8];
                        end
                        default:
                        begin
                            addr_d     = 16'(ix_ea + bus_seq_pkg::STEP_ONE);
                            vma_d      = 1'b1;
                            rd_wr_n_d  = 1'b0;
                            data_out_d = word_data[7:0];
                        end
                    endcase
                end
                bus_seq_pkg::k_idx_call_subroutine:
                begin
                    unique case (cycle_d)
                        bus_seq_pkg::CYC_THIRD:  addr_d = ix_v;
                        bus_seq_pkg::CYC_FOURTH:
                        begin
                            addr_d     = sp_v;
                            vma_d      = 1'b1;
                            rd_wr_n_d  = 1'b0;
                            data_out_d = ret_addr[7:0];
                        end
                        bus_seq_pkg::CYC_FIFTH:
                        begin
                            addr_d     = 16'(sp_v - bus_seq_pkg::STEP_ONE);
                            vma_d      = 1'b1;
                            rd_wr_n_d  = 1'b0;
                            data_out_d = ret_addr[15:8];
                        end
                        bus_seq_pkg::CYC_SIXTH:   addr_d = 16'(sp_v - bus_seq_pkg::STEP_TWO);
                        bus_seq_pkg::CYC_SEVENTH: addr_d = ix_v;
                        default:                  addr_d = ix_nc;
                    endcase
                end
                bus_seq_pkg::k_ext_jump_absolute,
                bus_seq_pkg::k_ext_read_operand,
                bus_seq_pkg::k_ext_load_word,
                bus_seq_pkg::k_ext_store_accumulator,
                bus_seq_pkg::k_ext_read_modify_write:
                begin
                    if (cycle_d == bus_seq_pkg::CYC_THIRD)
                    begin
                        addr_d = 16'(pc_v + bus_seq_pkg::STEP_TWO);
                        vma_d  = 1'b1;
                    end
                    else if (kind_d == bus_seq_pkg::k_ext_read_operand)
                    begin
                        addr_d = ext_ea;
                        vma_d  = 1'b1;
                    end
                    else if (kind_d == bus_seq_pkg::k_ext_load_word)
                    begin
                        addr_d = (cycle_d == bus_seq_pkg::CYC_FOURTH) ? ext_ea :
                                 16'(ext_ea + bus_seq_pkg::STEP_ONE);
                        vma_d  = 1'b1;
                    end
                    else if (kind_d == bus_seq_pkg::k_ext_store_accumulator)
                    begin
                        addr_d = ext_ea;
                        if (cycle_d == bus_seq_pkg::CYC_FIFTH)
                        begin
                            vma_d      = 1'b1;
                            rd_wr_n_d  = 1'b0;
                            data_out_d = acc_data;
                        end
                    end
                    else
                    begin
                        addr_d = ext_ea;
                        if (cycle_d == bus_seq_pkg::CYC_FOURTH)
                            vma_d = 1'b1;
                        else if (cycle_d == bus_seq_pkg::CYC_SIXTH && !test_d)
                        begin
                            vma_d      = 1'b1;
                            rd_wr_n_d  = 1'b0;
                            data_out_d = new_data;
                        end
                    end
                end
                default: addr_d = bus_seq_pkg::ADDR_RST;
            endcase
        end
        if (!vma_d)
        begin
            rd_wr_n_d  = 1'b1;
            data_out_d = bus_seq_pkg::BYTE_RST;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cycle_q                <= bus_seq_pkg::CYC_IDLE;
            kind_q                 <= bus_seq_pkg::k_ext_jump_absolute;
            test_q                 <= 1'b0;
            addr_hi_q              <= bus_seq_pkg::BYTE_RST;
            addr_lo_q              <= bus_seq_pkg::BYTE_RST;
            operand_q              <= bus_seq_pkg::WORD_RST;
            addr_q                 <= bus_seq_pkg::ADDR_RST;
            valid_memory_address_q <= 1'b0;
            rd_wr_n_q              <= 1'b1;
            data_out_q             <= bus_seq_pkg::BYTE_RST;
            last_cycle_q           <= 1'b0;
        end
        else
        begin
            cycle_q                <= cycle_d;
            kind_q                 <= kind_d;
            test_q                 <= test_d;
            addr_hi_q              <= addr_hi_d;
            addr_lo_q              <= addr_lo_d;
            operand_q              <= operand_d;
            addr_q                 <= addr_d;
            valid_memory_address_q <= vma_d;
            rd_wr_n_q              <= rd_wr_n_d;
            data_out_q             <= data_out_d;
            last_cycle_q           <= last_cycle_d;
        end
    end

    assign target_q = {addr_hi_q, addr_lo_q};

endmodule : bus_cycle_sequencer
`default_nettype wire

// ### test/mem_model.sv
// Memory and peripheral model on the sequencer's bus.
// Assumes one bus cycle per mclk; reads are answered within the cycle.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Bus
    input  wire logic [15:0] addr,
    input  wire logic        valid_memory_address,
    input  wire logic        rd_wr_n,
    input  wire logic [7:0]  data_out,
    output logic      [7:0]  data_in,
    // Write log
    output logic      [15:0] wr_count
);
    logic flip_q;
    assign data_in = (valid_memory_address && rd_wr_n) ? (addr[7:0] ^ addr[15:8] ^ 8'h5A) : (flip_q ? 8'hA5 : 8'h5A);
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            flip_q   <= 1'b0;
            wr_count <= 16'h0000;
        end
        else
        begin
            flip_q <= ~flip_q;
            if (valid_memory_address && !rd_wr_n)
                wr_count <= wr_count + 16'h0001;
        end
    end
endmodule : mem_model
`default_nettype wire

// ### test/bus_seq_chk.sv
// Assertions on the sequencer's top-level ports.
// Assumes start inputs are held while an instruction runs.
`timescale 1ns/1ps
`default_nettype none
module bus_seq_chk (
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  rst,
    // Instruction start
    input wire logic                  start,
    input wire bus_seq_pkg::op_kind_t kind,
    input wire logic [15:0]           opcode_addr,
    input wire logic [15:0]           stack_ptr,
    // Bus and status
    input wire logic [15:0]           addr_q,
    input wire logic                  valid_memory_address_q,
    input wire logic                  rd_wr_n_q,
    input wire logic                  busy,
    input wire logic                  last_cycle_q,
    input wire logic [3:0]            cycle_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Two pushes then idle below them
    sequence s_push;
        valid_memory_address_q && !rd_wr_n_q && addr_q == stack_ptr
        ##1 valid_memory_address_q && !rd_wr_n_q && addr_q == stack_ptr - 16'h0001
        ##1 !valid_memory_address_q && rd_wr_n_q && addr_q == stack_ptr - 16'h0002;
    endsequence
    strobe_read_a: assert property (!valid_memory_address_q |-> rd_wr_n_q)
        else $error("write direction with strobe low");
    take_fetch_a: assert property (start && (cycle_q == 4'h0 || last_cycle_q) |=>
        cycle_q == 4'h1 && valid_memory_address_q && addr_q == $past(opcode_addr))
        else $error("opcode fetch missing");
    cycle_step_a: assert property (busy && !last_cycle_q |=> cycle_q == $past(cycle_q) + 4'h1)
        else $error("cycle count did not step");
    jump_len_a: assert property (cycle_q == 4'h1 && $past(kind) == bus_seq_pkg::k_ext_jump_absolute
        |-> !last_cycle_q ##2 last_cycle_q)
        else $error("jump length wrong");
    call_len_a: assert property (cycle_q == 4'h1 && $past(kind) == bus_seq_pkg::k_idx_call_subroutine
        |-> !last_cycle_q [*7] ##1 last_cycle_q)
        else $error("call length wrong");
    call_push_a: assert property (cycle_q == 4'h3 && !last_cycle_q
        && kind == bus_seq_pkg::k_idx_call_subroutine |=> s_push)
        else $error("call push order wrong");
    word_pair_a: assert property (valid_memory_address_q && !rd_wr_n_q && cycle_q == 4'h6 && !last_cycle_q
        |=> valid_memory_address_q && !rd_wr_n_q && last_cycle_q && addr_q == $past(addr_q) + 16'h0001)
        else $error("word low byte not one above");
    ext_rmw_a: assert property (cycle_q == 4'h4 && kind == bus_seq_pkg::k_ext_read_modify_write
        && !last_cycle_q |-> valid_memory_address_q
        ##1 !valid_memory_address_q && $stable(addr_q) ##1 last_cycle_q && $stable(addr_q))
        else $error("rmw read idle write wrong");
endmodule : bus_seq_chk
bind bus_cycle_sequencer bus_seq_chk i_chk (.mclk, .rst, .start, .kind, .opcode_addr, .stack_ptr, .addr_q,
    .valid_memory_address_q, .rd_wr_n_q, .busy, .last_cycle_q, .cycle_q);
`default_nettype wire

// ### test/tb_bus_cycle_sequencer.sv
// Random and corner-case bench for the bus cycle sequencer.
// Assumes mem_model answers reads; expectations from the bus walk.
`timescale 1ns/1ps
`default_nettype none
module tb_bus_cycle_sequencer;
    logic                  mclk, rst, start, test_only, valid_memory_address, rw, busy, last;
    bus_seq_pkg::op_kind_t kind;
    logic [15:0]           pc, ix, sp, word, addr, wr_count, operand, target;
    logic [7:0]            acc, nd, data_in, data_out;
    logic [3:0]            cyc;
    logic [31:0]           seed = 32'h8F91;
    int                    n_errors = 0, checks_done = 0, n_wr = 0;
    int                    lens [9] = '{6, 7, 7, 8, 3, 4, 5, 5, 6};
    bus_cycle_sequencer i_dut (.mclk, .rst, .start, .kind, .test_only, .opcode_addr(pc), .index_reg(ix),
        .stack_ptr(sp), .acc_data(acc), .word_data(word), .new_data(nd), .data_in, .addr_q(addr),
        .valid_memory_address_q(valid_memory_address), .rd_wr_n_q(rw), .data_out_q(data_out), .busy, .last_cycle_q(last),
        .cycle_q(cyc), .operand_q(operand), .target_q(target));
    mem_model i_mem (.mclk, .rst, .addr, .valid_memory_address, .rd_wr_n(rw), .data_out, .data_in, .wr_count);
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [7:0] mb(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : mb
    // Expected {address, strobe, direction, data} of cycle k
    function automatic logic [25:0] walk(input int kd, input int k);
        logic [7:0]  off;
        logic [15:0] nc, ea, xa, ret;
        logic        t;
        off = mb(pc + 16'h0001);
        nc = {ix[15:8], ix[7:0] + off};
        ea = ix + {8'h00, off};
        xa = {off, mb(pc + 16'h0002)};
        ret = pc + 16'h0002;
        t = test_only;
        if (k < 3)
            return {pc + 16'(k - 1), 2'b11, 8'h00};
        if (kd >= 4)
            case (k)
                3: return {pc + 16'h0002, 2'b11, 8'h00};
                4: return {xa, kd != 7, 1'b1, 8'h00};
                5: return kd == 6 ? {xa + 16'h0001, 10'h300} : kd == 7 ? {xa, 2'b10, acc} : {xa, 10'h100};
                default: return {xa, ~t, t, t ? 8'h00 : nd};
            endcase
        case (k)
            3: return {ix, 10'h100};
            4: return kd == 3 ? {sp, 2'b10, ret[7:0]} : {nc, 10'h100};
            5: return kd == 3 ? {sp - 16'h0001, 2'b10, ret[15:8]} : {ea, kd == 1, 9'h100};
            6: return kd == 3 ? {sp - 16'h0002, 10'h100} : kd == 0 ? {ea, 2'b10, acc} :
                kd == 2 ? {ea, 2'b10, word[15:8]} : {ea, 10'h100};
            7: return kd == 3 ? {ix, 10'h100} : kd == 2 ? {ea + 16'h0001, 2'b10, word[7:0]} :
                {ea, ~t, t, t ? 8'h00 : nd};
            default: return {nc, 10'h100};
        endcase
    endfunction : walk
    task automatic check(input string name, input logic [25:0] seen, input logic [25:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic run(input int kd, input logic tst, input bit corner);
        logic [25:0] e;
        kind = bus_seq_pkg::op_kind_t'(kd);
        test_only = tst;
        seed = xs(seed);
        pc = corner ? 16'hFFFE : seed[15:0];
        ix = corner ? 16'h12FF : seed[31:16];
        seed = xs(seed);
        sp = corner ? 16'h0001 : seed[15:0];
        word = seed[31:16];
        seed = xs(seed);
        acc = seed[7:0];
        nd = seed[15:8];
        start = 1'b1;
        for (int k = 1; k <= lens[kd]; k++)
        begin
            @(posedge mclk);
            #1;
            if (k == 1)
                start = seed[16];
            e = walk(kd, k);
            if (e[9] && !e[8])
                n_wr++;
            check("addr", {10'h0, addr}, 26'(e[25:10]));
            check("bus", {16'h0, valid_memory_address, rw, data_out}, 26'(e[9:0]));
            check("status", {20'h0, busy, last, cyc}, {20'h0, 1'b1, k == lens[kd], k[3:0]});
            if ((kd == 1 || kd == 8) && k == lens[kd])
                check("operand", {18'h0, operand[7:0]}, {18'h0, mb(e[25:10])});
            if (kd >= 5 && k == 4)
                check("target", {10'h0, target}, {10'h0, e[25:10]});
        end
    endtask : run
    task automatic idle_gap;
        start = 1'b0;
        @(posedge mclk);
        #1;
        check("idle", {addr, valid_memory_address, rw, data_out}, {16'h0000, 10'h100});
        check("idle status", {20'h0, busy, last, cyc}, 26'h0);
    endtask : idle_gap
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    initial
    begin
        {rst, start, test_only, pc, ix, sp, word, acc, nd} = {3'b100, 80'h0};
        kind = bus_seq_pkg::k_idx_store_accumulator;
        repeat (4) @(posedge mclk);
        #1;
        rst = 1'b0;
        for (int r = 0; r < 12; r++)
        begin
            for (int kd = 0; kd < 9; kd++)
            begin
                run(kd, 1'b0, r == 0);
                if (kd == 1 || kd == 8)
                    run(kd, 1'b1, r == 0);
                if (seed[20])
                    idle_gap();
            end
            $display("round %0d done, checks %0d", r, checks_done);
        end
        idle_gap();
        check("writes", {10'h0, wr_count}, 26'(n_wr));
        summarize();
    end
    initial
    begin
        repeat (4000) @(posedge mclk);
        n_errors++;
        summarize();
    end
endmodule : tb_bus_cycle_sequencer
`default_nettype wire
